//--- fsc_pkg.sv
// Package for the fault snapshot capture block: command codes, register
// offsets, record size and flash timing.
// Assumes a 200 MHz core clock and a simple strobe register port.
package fsc_pkg;

  localparam int unsigned CLK_MHZ        = 200;
  // Longest record write to flash, in microseconds
  localparam int unsigned FLASH_WR_US    = 1400;
  localparam int unsigned FLASH_WR_CYC   = FLASH_WR_US * CLK_MHZ;
  // Store copy time, kept short and fixed
  localparam int unsigned STORE_CYC      = 64;

  localparam int unsigned REC_BYTES      = 32;
  localparam int unsigned REC_AW         = 5;
  localparam int unsigned CFG_BYTES      = 16;
  localparam int unsigned CFG_AW         = 4;

  // Register word addresses
  localparam logic [7:0] REG_MISC        = 8'h00;
  localparam logic [7:0] REG_REC_CTRL    = 8'h04;
  localparam logic [7:0] REG_STATUS      = 8'h08;
  localparam logic [7:0] REG_STORE_CMD   = 8'h0c;
  localparam logic [7:0] REG_AVAIL       = 8'h10;
  localparam logic [7:0] REG_REC_PTR     = 8'h14;
  localparam logic [7:0] REG_REC_DATA    = 8'h18;
  localparam logic [7:0] REG_CFG_PTR     = 8'h1c;
  localparam logic [7:0] REG_CFG_DATA    = 8'h20;

  localparam int unsigned MISC_REC_EN_BIT = 1;

  localparam logic [7:0] CTRL_TO_RAM     = 8'h01;
  localparam logic [7:0] CTRL_TO_FLASH   = 8'h02;

  localparam logic [7:0] CMD_STORE_DEF   = 8'h11;
  localparam logic [7:0] CMD_RESTORE_DEF = 8'h12;
  localparam logic [7:0] CMD_STORE_USR   = 8'h15;
  localparam logic [7:0] CMD_RESTORE_USR = 8'h16;

  localparam logic [1:0] AVAIL_RESET     = 2'h3;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } fsc_req_t;

  typedef enum logic [4:0] {
    ST_INIT   = 5'b00001,
    ST_IDLE   = 5'b00010,
    ST_FL_WR  = 5'b00100,
    ST_FL_RD  = 5'b01000,
    ST_STORE  = 5'b10000
  } fsc_state_t;

endpackage : fsc_pkg

//--- fsc_top.sv
// Fault snapshot capture and configuration store logic.
// Assumes the firmware tick, module-enable and fault inputs come from logic
// on the same clock; the nonvolatile arrays are modelled by registers.
`timescale 1ns/10ps

// Functional notes
// - Recording runs only while control bit 1 is set; clearing stops it.
// - Record is 32 bytes, read out byte by byte any time.
// - While recording, RAM record refreshed each firmware tick outside a flash write.
// - Recording off: RAM record frozen, fault values kept.
// - Control value 1 copies flash record into RAM.
// - Control value 2 writes record to flash, only when module disabled.
// - Fault with shutdown response writes record to flash automatically.
// - Fault with retry response never writes flash.
// - Record flash write takes up to 1400 us; busy meanwhile.
// - After copy, the record read returns the RAM record.
// - Flash record survives power cycle; copy and read retrieve it.
// - At start-up the stores are checked before settings are used.
// - Two configuration stores, default and user, each full image.
// - Restore-default command reloads working settings from default store.
// - Restore only from levels made available; others refused.
// - Store-user command saves working settings into user store.
// - Store-default command saves working settings into default store.
module fsc_top #(
  parameter int unsigned FLASH_WR_CYCLES = fsc_pkg::FLASH_WR_CYC
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire fsc_pkg::fsc_req_t req,
  output logic [31:0]      rdata,
  input  wire logic        fw_tick,
  input  wire logic [7:0]  live_param [fsc_pkg::REC_BYTES],
  input  wire logic        module_en,
  input  wire logic        fault_shutdown,
  input  wire logic        fault_retry,
  output logic             flash_busy,
  output logic             cfg_valid
);

  localparam int unsigned CW = 32;

  function automatic logic hit(input fsc_pkg::fsc_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction : hit

  // A restore is refused when its level has not been made available
  function automatic logic restore_refused(input logic [7:0] c, input logic [1:0] av);
    restore_refused = (c == fsc_pkg::CMD_RESTORE_DEF && !av[0]) ||
                      (c == fsc_pkg::CMD_RESTORE_USR && !av[1]);
  endfunction : restore_refused

  function automatic logic ctrl_is(input fsc_pkg::fsc_req_t r, input logic [7:0] v);
    ctrl_is = r.wr && (r.addr == fsc_pkg::REG_REC_CTRL) && (r.wdata[7:0] == v);
  endfunction : ctrl_is

  //////////////////////////////////////////////////////////////////////////
  // State
  fsc_pkg::fsc_state_t state_q;
  logic [CW-1:0]       cnt_q;
  logic                rec_en_q;
  logic [7:0]          misc_q;
  logic                pend_ram_q;
  logic                pend_fl_q;
  logic                fault_pend_q;
  logic [7:0]          store_cmd_q;
  logic                refused_q;
  logic [1:0]          avail_q;
  logic [fsc_pkg::REC_AW-1:0] rec_ptr_q;
  logic [fsc_pkg::CFG_AW-1:0] cfg_ptr_q;
  logic [7:0]          rec_ram  [fsc_pkg::REC_BYTES];
  logic [7:0]          rec_fl   [fsc_pkg::REC_BYTES];
  logic [7:0]          cfg_work [fsc_pkg::CFG_BYTES];
  logic [7:0]          cfg_def  [fsc_pkg::CFG_BYTES];
  logic [7:0]          cfg_usr  [fsc_pkg::CFG_BYTES];

  logic wr_misc, wr_cmd, store_go, store_done, is_idle, done;
  assign wr_misc    = req.wr && hit(req, fsc_pkg::REG_MISC);
  assign wr_cmd     = req.wr && hit(req, fsc_pkg::REG_STORE_CMD);
  assign store_go   = wr_cmd && !restore_refused(req.wdata[7:0], avail_q);
  assign store_done = (state_q == fsc_pkg::ST_STORE) && done;
  assign is_idle = (state_q == fsc_pkg::ST_IDLE);
  assign done    = (cnt_q == '0);

  //////////////////////////////////////////////////////////////////////////
  // Control register; recording enable is bit 1
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      misc_q <= 8'h00;
    end else if (wr_misc) begin
      misc_q <= req.wdata[7:0];
    end
  end
  assign rec_en_q = misc_q[fsc_pkg::MISC_REC_EN_BIT];

  //////////////////////////////////////////////////////////////////////////
  // Pending requests; a new request wins over the clear in the same cycle
  // A flag clears only in the cycle in which the sequencer takes it
  // Copy deferred while a flash write is due or running
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_ram_q <= 1'b0;
    end else if (ctrl_is(req, fsc_pkg::CTRL_TO_RAM)) begin
      pend_ram_q <= 1'b1;
    end else if (is_idle && !fault_pend_q && !pend_fl_q) begin
      pend_ram_q <= 1'b0;
    end
  end

  // Write only while module disabled
  // One flash write serves a host save and a fault save alike
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pend_fl_q <= 1'b0;
    end else if (ctrl_is(req, fsc_pkg::CTRL_TO_FLASH) && !module_en) begin
      pend_fl_q <= 1'b1;
    end else if (is_idle) begin
      pend_fl_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fault_pend_q <= 1'b0;
    end else if (fault_shutdown) begin
      fault_pend_q <= 1'b1;
    end else if (is_idle) begin
      fault_pend_q <= 1'b0;
    end
  end

  // Refusal is sticky until next command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      refused_q <= 1'b0;
    end else if (wr_cmd) begin
      refused_q <= restore_refused(req.wdata[7:0], avail_q);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer; a fault save outranks a pending copy so that the fault
  // values reach flash before a copy can overwrite the RAM record
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= fsc_pkg::ST_INIT;
    end else begin
      unique case (state_q)
        // Load working settings after store check
        fsc_pkg::ST_INIT: begin
          state_q <= fsc_pkg::ST_STORE;
        end
        fsc_pkg::ST_IDLE: begin
          if (fault_pend_q || pend_fl_q) begin
            state_q <= fsc_pkg::ST_FL_WR;
          end else if (pend_ram_q) begin
            state_q <= fsc_pkg::ST_FL_RD;
          end else if (store_go) begin
            state_q <= fsc_pkg::ST_STORE;
          end
        end
        fsc_pkg::ST_FL_WR, fsc_pkg::ST_FL_RD, fsc_pkg::ST_STORE: begin
          if (done) begin
            state_q <= fsc_pkg::ST_IDLE;
          end
        end
        default: state_q <= fsc_pkg::ST_IDLE;
      endcase
    end
  end

  // Step counter, loaded as a timed state is entered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        fsc_pkg::ST_INIT: begin
          cnt_q <= CW'(fsc_pkg::STORE_CYC);
        end
        fsc_pkg::ST_IDLE: begin
          if (fault_pend_q || pend_fl_q) begin
            // Busy for the full write time
            cnt_q <= CW'(FLASH_WR_CYCLES);
          end else if (pend_ram_q) begin
            cnt_q <= CW'(fsc_pkg::REC_BYTES);
          end else if (store_go) begin
            cnt_q <= CW'(fsc_pkg::STORE_CYC);
          end
        end
        fsc_pkg::ST_FL_WR, fsc_pkg::ST_FL_RD, fsc_pkg::ST_STORE: begin
          if (!done) begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        default: cnt_q <= '0;
      endcase
    end
  end

  // Store command latched only when the sequencer accepts it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      store_cmd_q <= 8'h00;
    end else if (state_q == fsc_pkg::ST_INIT) begin
      store_cmd_q <= fsc_pkg::CMD_RESTORE_DEF;
    end else if (is_idle && !fault_pend_q && !pend_fl_q && !pend_ram_q && store_go) begin
      store_cmd_q <= req.wdata[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Record RAM and flash image (flash has no reset, it survives power loss)
  always_ff @(posedge clk) begin
    if (rec_en_q && fw_tick && state_q != fsc_pkg::ST_FL_WR) begin
      rec_ram <= live_param;
    end else if (state_q == fsc_pkg::ST_FL_RD && done) begin
      // Flash image kept across power loss
      rec_ram <= rec_fl;
    end
  end

  // Flash image changes only once the write time has run out
  always_ff @(posedge clk) begin
    if (state_q == fsc_pkg::ST_FL_WR && done) begin
      rec_fl <= rec_ram;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration stores
  // Host writes, or reload from default or user store
  always_ff @(posedge clk) begin
    if (req.wr && hit(req, fsc_pkg::REG_CFG_DATA)) begin
      cfg_work[cfg_ptr_q] <= req.wdata[7:0];
    end else if (store_done && store_cmd_q == fsc_pkg::CMD_RESTORE_DEF) begin
      cfg_work <= cfg_def;
    end else if (store_done && store_cmd_q == fsc_pkg::CMD_RESTORE_USR) begin
      cfg_work <= cfg_usr;
    end
  end

  always_ff @(posedge clk) begin
    if (store_done && store_cmd_q == fsc_pkg::CMD_STORE_DEF) begin
      cfg_def <= cfg_work;
    end
  end

  always_ff @(posedge clk) begin
    if (store_done && store_cmd_q == fsc_pkg::CMD_STORE_USR) begin
      cfg_usr <= cfg_work;
    end
  end

  // Levels made available for restore
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avail_q <= fsc_pkg::AVAIL_RESET;
    end else if (req.wr && hit(req, fsc_pkg::REG_AVAIL)) begin
      avail_q <= req.wdata[1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rec_ptr_q <= '0;
    end else if (req.wr && hit(req, fsc_pkg::REG_REC_PTR)) begin
      rec_ptr_q <= req.wdata[fsc_pkg::REC_AW-1:0];
    end else if (req.rd && hit(req, fsc_pkg::REG_REC_DATA)) begin
      rec_ptr_q <= rec_ptr_q + fsc_pkg::REC_AW'(1);
    end
  end

  // Config pointer steps on every data access, read or write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ptr_q <= '0;
    end else if (req.wr && hit(req, fsc_pkg::REG_CFG_PTR)) begin
      cfg_ptr_q <= req.wdata[fsc_pkg::CFG_AW-1:0];
    end else if ((req.wr || req.rd) && hit(req, fsc_pkg::REG_CFG_DATA)) begin
      cfg_ptr_q <= cfg_ptr_q + fsc_pkg::CFG_AW'(1);
    end
  end

  // Working settings valid once the start-up load has finished
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_valid <= 1'b0;
    end else if (store_done) begin
      cfg_valid <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Busy flag, registered so that the pin comes straight from a flip-flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flash_busy <= 1'b0;
    end else begin
      flash_busy <= (state_q == fsc_pkg::ST_FL_WR) && !done;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= '0;
    end else begin
      rdata <= '0;
      if (req.rd) begin
        unique case (req.addr)
          fsc_pkg::REG_MISC:     rdata <= {24'h000000, misc_q};
          fsc_pkg::REG_STATUS:   rdata <= {24'h000000, 3'h0, state_q};
          fsc_pkg::REG_STORE_CMD: rdata <= {23'h000000, refused_q, store_cmd_q};
          fsc_pkg::REG_AVAIL:    rdata <= {30'h00000000, avail_q};
          fsc_pkg::REG_REC_PTR:  rdata <= {27'h0000000, rec_ptr_q};
          fsc_pkg::REG_REC_DATA: rdata <= {24'h000000, rec_ram[rec_ptr_q]};
          fsc_pkg::REG_CFG_PTR:  rdata <= {28'h0000000, cfg_ptr_q};
          fsc_pkg::REG_CFG_DATA: rdata <= {24'h000000, cfg_work[cfg_ptr_q]};
          default:               rdata <= '0;
        endcase
      end
    end
  end

endmodule : fsc_top

//--- fsc_top_sva.sv
// Checker for the fault snapshot block, watching top-level ports only.
// Assumes a single clock domain and the bind at the foot of this file.
`timescale 1ns/10ps
module fsc_top_sva #(
  parameter int unsigned FLASH_WR_CYCLES = 50
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire fsc_pkg::fsc_req_t req,
  input wire logic [31:0]       rdata,
  input wire logic              module_en,
  input wire logic              fault_shutdown,
  input wire logic              fault_retry,
  input wire logic              flash_busy,
  input wire logic              cfg_valid
);
  localparam int BUSY_HI = FLASH_WR_CYCLES + 2;
  logic ctrl2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  assign ctrl2 = req.wr && req.addr == fsc_pkg::REG_REC_CTRL
                 && req.wdata[7:0] == fsc_pkg::CTRL_TO_FLASH;
  //////////////////////////////////////////////////////////////////////////
  a_ctrl_save:
    assert property (ctrl2 && !module_en && !flash_busy |-> ##[2:40] flash_busy)
    else $error("record save not started");
  a_ctrl_refuse:
    assert property (ctrl2 && module_en && !flash_busy && !fault_shutdown |-> ##2 !flash_busy)
    else $error("record save accepted while module on");
  a_fault_save:
    assert property ($rose(fault_shutdown) && !flash_busy |-> ##[2:40] flash_busy)
    else $error("shutdown fault did not save record");
  a_retry_none:
    assert property (fault_retry && !fault_shutdown && !req.wr && !flash_busy
                     && !$past(req.wr) && !$past(fault_shutdown) |-> ##2 !flash_busy)
    else $error("retry fault started a flash write");
  a_busy_min:
    assert property ($rose(flash_busy) |-> flash_busy[*8])
    else $error("flash busy dropped early");
  a_busy_end:
    assert property ($rose(flash_busy) |-> ##[1:BUSY_HI] !flash_busy)
    else $error("flash write overran its time");
  a_rdata_idle:
    assert property (!$past(req.rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");
  a_cfg_hold:
    assert property (cfg_valid |=> cfg_valid)
    else $error("working config lost");
endmodule : fsc_top_sva

bind fsc_top fsc_top_sva #(.FLASH_WR_CYCLES(FLASH_WR_CYCLES)) i_fsc_top_sva (
  .clk(clk), .rstn(rstn), .req(req), .rdata(rdata), .module_en(module_en),
  .fault_shutdown(fault_shutdown), .fault_retry(fault_retry),
  .flash_busy(flash_busy), .cfg_valid(cfg_valid));

//--- fsc_host.sv
// Register bus master standing in for the system controller.
// Assumes the slave answers a read in the next cycle and never stalls.
`timescale 1ns/10ps
module fsc_host (
  input  wire logic              clk,
  output fsc_pkg::fsc_req_t      req,
  input  wire logic [31:0]       rdata
);
  initial req = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
endmodule : fsc_host

//--- tb_top.sv
// Self-checking bench for the fault snapshot block.
// Assumes a short flash write parameter so the run stays brief.
`timescale 1ns/10ps
module tb_top;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  fsc_pkg::fsc_req_t req;
  logic [31:0]       rdata;
  logic              fw_tick = 1'b0, module_en = 1'b0;
  logic              fault_shutdown = 1'b0, fault_retry = 1'b0;
  logic [7:0]        live [fsc_pkg::REC_BYTES];
  logic              flash_busy, cfg_valid;
  int                n_mismatch = 0;
  int                comparisons = 0;
  logic [31:0]       d;
  always #2.5 clk = ~clk;
  fsc_host i_fsc_host (.clk(clk), .req(req), .rdata(rdata));
  fsc_top #(.FLASH_WR_CYCLES(50)) i_fsc_top (.clk(clk), .rstn(rstn), .req(req),
    .rdata(rdata), .fw_tick(fw_tick), .live_param(live), .module_en(module_en),
    .fault_shutdown(fault_shutdown), .fault_retry(fault_retry),
    .flash_busy(flash_busy), .cfg_valid(cfg_valid));
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_of_test();
    if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 100 && flash_busy !== v; i++) @(posedge clk);
    chk("flash_busy", flash_busy, v);
  endtask : wait_busy
  task automatic capture(input logic [7:0] base, input logic en);
    int i;
    i_fsc_host.wr(fsc_pkg::REG_MISC, {30'h0, en, 1'b0});
    @(posedge clk);
    for (i = 0; i < 32; i++) live[i] <= base + 8'(i);
    fw_tick <= 1'b1;
    @(posedge clk);
    fw_tick <= 1'b0;
    i_fsc_host.wr(fsc_pkg::REG_MISC, 32'h0);
  endtask : capture
  task automatic read_rec(input logic [7:0] base);
    int i;
    i_fsc_host.wr(fsc_pkg::REG_REC_PTR, 32'h0);
    for (i = 0; i < 32; i++) begin
      i_fsc_host.rd(fsc_pkg::REG_REC_DATA, d);
      chk("rec_byte", d, {24'h0, base + 8'(i)});
    end
  endtask : read_rec
  //////////////////////////////////////////////////////////////////////////
  task automatic t_record();
    capture(8'h10, 1'b1);
    read_rec(8'h10);
    capture(8'ha0, 1'b0);
    read_rec(8'h10);
  endtask : t_record
  task automatic t_flash();
    module_en <= 1'b1;
    i_fsc_host.wr(fsc_pkg::REG_REC_CTRL, 32'h2);
    repeat (10) @(posedge clk);
    chk("busy_module_on", flash_busy, 1'b0);
    module_en <= 1'b0;
    i_fsc_host.wr(fsc_pkg::REG_REC_CTRL, 32'h2);
    wait_busy(1'b1);
    wait_busy(1'b0);
    capture(8'h40, 1'b1);
    read_rec(8'h40);
    // module and recording off, copy flash record into RAM
    i_fsc_host.wr(fsc_pkg::REG_REC_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    read_rec(8'h10);
  endtask : t_flash
  task automatic t_fault();
    fault_retry <= 1'b1;
    @(posedge clk);
    fault_retry <= 1'b0;
    repeat (10) @(posedge clk);
    chk("busy_retry", flash_busy, 1'b0);
    fault_shutdown <= 1'b1;
    @(posedge clk);
    fault_shutdown <= 1'b0;
    wait_busy(1'b1);
    wait_busy(1'b0);
  endtask : t_fault
  task automatic t_store();
    i_fsc_host.rd(fsc_pkg::REG_AVAIL, d);
    chk("avail_reset", d[1:0], fsc_pkg::AVAIL_RESET);
    i_fsc_host.wr(fsc_pkg::REG_AVAIL, 32'h0);
    i_fsc_host.wr(fsc_pkg::REG_STORE_CMD, {24'h0, fsc_pkg::CMD_RESTORE_DEF});
    i_fsc_host.rd(fsc_pkg::REG_STORE_CMD, d);
    chk("restore_refused", d[8], 1'b1);
  endtask : t_store
  task automatic t_cfg();
    int i;
    int j;
    i_fsc_host.wr(fsc_pkg::REG_AVAIL, {30'h0, fsc_pkg::AVAIL_RESET});
    i_fsc_host.wr(fsc_pkg::REG_CFG_PTR, 32'h0);
    for (i = 0; i < 16; i++) i_fsc_host.wr(fsc_pkg::REG_CFG_DATA, 32'h30 + i);
    i_fsc_host.wr(fsc_pkg::REG_STORE_CMD, {24'h0, fsc_pkg::CMD_STORE_USR});
    repeat (80) @(posedge clk);
    i_fsc_host.wr(fsc_pkg::REG_STORE_CMD, {24'h0, fsc_pkg::CMD_STORE_DEF});
    repeat (80) @(posedge clk);
    for (j = 0; j < 2; j++) begin
      i_fsc_host.wr(fsc_pkg::REG_CFG_PTR, 32'h0);
      for (i = 0; i < 16; i++) i_fsc_host.wr(fsc_pkg::REG_CFG_DATA, 32'h0);
      i_fsc_host.wr(fsc_pkg::REG_STORE_CMD, {24'h0, (j == 0) ? fsc_pkg::CMD_RESTORE_DEF
                                                             : fsc_pkg::CMD_RESTORE_USR});
      repeat (80) @(posedge clk);
      i_fsc_host.rd(fsc_pkg::REG_STORE_CMD, d);
      chk("restore_taken", d[8], 1'b0);
      i_fsc_host.wr(fsc_pkg::REG_CFG_PTR, 32'h0);
      for (i = 0; i < 16; i++) begin
        i_fsc_host.rd(fsc_pkg::REG_CFG_DATA, d);
        chk("cfg_byte", d, 32'h30 + i);
      end
    end
  endtask : t_cfg
  initial begin
    for (int i = 0; i < 32; i++) live[i] = 8'h0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 200 && cfg_valid !== 1'b1; i++) @(posedge clk);
    chk("cfg_valid", cfg_valid, 1'b1);
    t_record();
    t_flash();
    t_fault();
    t_store();
    t_cfg();
    end_of_test();
  end
  initial begin
    #50000;
    n_mismatch++;
    end_of_test();
  end
endmodule : tb_top
